/* File: logic/iscr_top.sv */
// Purpose: axi4-lite slave holding the slave control words of both i2c instances
// Assumes: one write and one read outstanding at most, per axi4-lite
// Notes: unmapped addresses answer slverr, reads of them return zero
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module iscr_top
	import iscr_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// axi write address
	input wire logic [31:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	// axi write data
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	// axi write response
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// axi read address
	input wire logic [31:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	// axi read data
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	// slave engine events and ack slots
	input wire iscr_evt_t [NUM_INST-1:0] I_EVT,
	input wire iscr_ack_t [NUM_INST-1:0] I_ACK_REQ,
	// per-instance answers
	output logic [NUM_INST-1:0] O_IRQ,
	output logic [NUM_INST-1:0] O_NACK,
	output logic [NUM_INST-1:0] O_ACK_VALID
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	iscr_wr_st_t wr_st_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [31:0] awaddr_r;
	logic [15:0] wdata_r;
	logic [1:0] wstrb_r;
	iscr_dec_t wdec;
	iscr_dec_t rdec;
	logic [NUM_INST-1:0] cell_we;
	logic [15:0] cell_ctl [NUM_INST];
	logic [15:0] cell_sts [NUM_INST];
	logic [15:0] cell_msk [NUM_INST];
	logic [15:0] rd_word;

	// ----------------------------------------
	// write channels
	// ----------------------------------------

	// address decode of the held write and the offered read
	assign wdec = iscr_decode(awaddr_r);
	assign rdec = iscr_decode(I_ARADDR);

	// address and data captured in either order, ready drops while held
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			awaddr_r <= 32'h00000000;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'h0;
		end else begin
			if (I_AWVALID && awready_r) begin
				awready_r <= 1'b0;
				awaddr_r <= I_AWADDR;
			end
			if (I_WVALID && wready_r) begin
				wready_r <= 1'b0;
				wdata_r <= I_WDATA[15:0];
				wstrb_r <= I_WSTRB[1:0];
			end
			// reopen both only after the response is taken
			if (bvalid_r && I_BREADY) begin
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// commit one cycle after both halves are held, then respond
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			wr_st_r <= WR_COLLECT;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			unique case (wr_st_r)
				WR_COLLECT: begin
					if (!awready_r && !wready_r) begin
						wr_st_r <= WR_COMMIT;
					end
				end
				WR_COMMIT: begin
					wr_st_r <= WR_RESP;
					bvalid_r <= 1'b1;
					bresp_r <= wdec.hit ? RESP_OKAY : RESP_SLVERR;
				end
				WR_RESP: begin
					if (I_BREADY) begin
						wr_st_r <= WR_COLLECT;
						bvalid_r <= 1'b0;
					end
				end
				default: begin
					wr_st_r <= WR_COLLECT;
					bvalid_r <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// read channels
	// ----------------------------------------

	// word selected by the read decode; a miss reads zero
	always_comb begin
		rd_word = 16'h0000;
		if (rdec.hit) begin
			unique case (rdec.sel)
				SEL_CTL: rd_word = cell_ctl[rdec.inst];
				SEL_STS: rd_word = cell_sts[rdec.inst];
				SEL_MSK: rd_word = cell_msk[rdec.inst];
				default: rd_word = 16'h0000;
			endcase
		end
	end

	// single-cycle read answer, upper half always zero
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else begin
			if (I_ARVALID && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= {16'h0000, rd_word};
				rresp_r <= rdec.hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && I_RREADY) begin
				arready_r <= 1'b1;
				rvalid_r <= 1'b0;
			end
		end
	end

	assign O_AWREADY = awready_r;
	assign O_WREADY = wready_r;
	assign O_BVALID = bvalid_r;
	assign O_BRESP = bresp_r;
	assign O_ARREADY = arready_r;
	assign O_RVALID = rvalid_r;
	assign O_RRESP = rresp_r;
	assign O_RDATA = rdata_r;

	// ----------------------------------------
	// instances
	// ----------------------------------------

	// checks share one clock; reset disables them all
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	for (genvar g = 0; g < NUM_INST; g++) begin : g_inst
		// one register set per peripheral instance
		assign cell_we[g] = (wr_st_r == WR_COMMIT) && wdec.hit && (wdec.inst == 1'(g));

		iscr_cell u_cell (
			.i_clk(I_CLK),
			.i_rst(I_RST),
			.i_we(cell_we[g]),
			.i_sel(wdec.sel),
			.i_wdata(wdata_r),
			.i_wbe(wstrb_r),
			.i_evt(I_EVT[g]),
			.i_ack(I_ACK_REQ[g]),
			.o_ctl(cell_ctl[g]),
			.o_sts(cell_sts[g]),
			.o_msk(cell_msk[g]),
			.o_irq(O_IRQ[g]),
			.o_nack(O_NACK[g]),
			.o_ack_vld(O_ACK_VALID[g])
		);

		// slot with the forced nack armed and no register write racing it
		sequence s_forced_slot;
			I_ACK_REQ[g].req && cell_ctl[g][BIT_NACK] && !cell_we[g];
		endsequence

		// slot left to the slave engine
		sequence s_free_slot;
			I_ACK_REQ[g].req && !cell_ctl[g][BIT_NACK];
		endsequence

		// answer appears next cycle and is a nack
		sequence s_nack_out;
			O_ACK_VALID[g] && O_NACK[g] && !cell_ctl[g][BIT_NACK];
		endsequence

		// control word zero right after reset
		a_ctl_reset_zero: assert property (
			$past(I_RST) |-> cell_ctl[g] == CTL_RST
		) else $error("control word not zero after reset");

		// transmit event latches and raises the line
		a_tx_irq_raise: assert property (
			I_EVT[g].tx_done && cell_ctl[g][BIT_TX] && cell_msk[g][BIT_TX] && !cell_we[g]
			|=> cell_sts[g][BIT_TX] && O_IRQ[g]
		) else $error("transmit event did not raise interrupt");

		// receive event latches and raises the line
		a_rx_irq_raise: assert property (
			I_EVT[g].rx_done && cell_ctl[g][BIT_RX] && cell_msk[g][BIT_RX] && !cell_we[g]
			|=> cell_sts[g][BIT_RX] && O_IRQ[g]
		) else $error("receive event did not raise interrupt");

		// stop detect latches and raises the line
		a_stop_irq_raise: assert property (
			I_EVT[g].stop_det && cell_ctl[g][BIT_STOP] && cell_msk[g][BIT_STOP] && !cell_we[g]
			|=> cell_sts[g][BIT_STOP] && O_IRQ[g]
		) else $error("stop event did not raise interrupt");

		// a status bit never rises while its enable was clear
		a_disabled_quiet: assert property (
			1'b1 |=> (cell_sts[g] & ~$past(cell_sts[g]) & ~$past(cell_ctl[g])) == 16'h0000
		) else $error("disabled event set a status bit");

		// armed nack answers the next slot and is spent
		a_forced_nack: assert property (
			s_forced_slot |=> s_nack_out
		) else $error("forced nack not given or not cleared");

		// free slot follows the engine decision
		a_hw_ack_pass: assert property (
			s_free_slot |=> O_ACK_VALID[g] && (O_NACK[g] == !$past(I_ACK_REQ[g].hw_ack))
		) else $error("ack answer differs from engine decision");

		a_rsvd_zero: assert property (
			cell_ctl[g][15:11] == 5'h00
		) else $error("reserved control bits not zero");

		// line equals the masked status merge
		a_irq_merge: assert property (
			$past(I_RST) == 1'b0 |-> O_IRQ[g] == |(cell_sts[g] & cell_msk[g])
		) else $error("interrupt line differs from masked status");

		a_ctl_write_lands: assert property (
			cell_we[g] && wdec.sel == SEL_CTL && wstrb_r == 2'h3
			|=> cell_ctl[g] == ($past(wdata_r) & CTL_WMASK)
		) else $error("control write did not land");

		a_miss_no_write: assert property (
			wr_st_r == WR_COMMIT && !wdec.hit && !I_ACK_REQ[g].req
			|=> $stable(cell_ctl[g])
		) else $error("unmapped write changed control word");

		// answer only moves at a slot
		a_nack_holds: assert property (
			!I_ACK_REQ[g].req |=> !O_ACK_VALID[g] && $stable(O_NACK[g])
		) else $error("ack answer moved without a slot");
	end

	// ----------------------------------------
	// bus checks
	// ----------------------------------------

	a_bresp_timely: assert property (
		wr_st_r == WR_COMMIT |=> O_BVALID
	) else $error("write response late");

	a_rresp_timely: assert property (
		I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY
	) else $error("read answer late");

	a_bus_reset_idle: assert property (
		$past(I_RST) |-> O_AWREADY && O_WREADY && O_ARREADY && !O_BVALID && !O_RVALID
	) else $error("bus side not idle after reset");

	// upper read half zero, the word is 16 bits
	a_rdata_upper_zero: assert property (
		O_RVALID |-> O_RDATA[31:16] == 16'h0000
	) else $error("read data upper half not zero");

endmodule // iscr_top

/* File: logic/iscr_pkg.sv */
// Purpose: constants, types and decode for the i2c slave control register block
// Assumes: two peripheral instances, 40 MHz clock, registers reached over axi4-lite
// Notes: status and mask words sit beside each control word
package iscr_pkg;

	// ----------------------------------------
	// addresses
	// ----------------------------------------
	localparam int NUM_INST = 2;
	localparam logic [31:0] ADDR_CTL0 = 32'hffff08a8;
	localparam logic [31:0] ADDR_CTL1 = 32'hffff0928;
	localparam logic [31:0] INST_BASE [NUM_INST] = '{ADDR_CTL0, ADDR_CTL1};
	localparam logic [31:0] OFS_CTL = 32'h00000000;
	localparam logic [31:0] OFS_STS = 32'h00000008;
	localparam logic [31:0] OFS_MSK = 32'h0000000c;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int BIT_TX = 10;
	localparam int BIT_RX = 9;
	localparam int BIT_STOP = 8;
	localparam int BIT_NACK = 7;
	localparam logic [15:0] CTL_WMASK = 16'h07ff;
	localparam logic [15:0] EVT_MASK = 16'h0700;
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] STS_RST = 16'h0000;
	localparam logic [15:0] MSK_RST = 16'h0700;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic tx_done;
		logic rx_done;
		logic stop_det;
	} iscr_evt_t;

	typedef struct packed {
		logic req;
		logic hw_ack;
	} iscr_ack_t;

	typedef enum logic [1:0] {
		SEL_CTL = 2'h0,
		SEL_STS = 2'h1,
		SEL_MSK = 2'h2
	} iscr_sel_t;

	typedef struct packed {
		logic hit;
		logic inst;
		iscr_sel_t sel;
	} iscr_dec_t;

	typedef enum logic [2:0] {
		WR_COLLECT = 3'h1,
		WR_COMMIT = 3'h2,
		WR_RESP = 3'h4
	} iscr_wr_st_t;

	// address to instance and word; misaligned or unknown is a miss
	function automatic iscr_dec_t iscr_decode(input logic [31:0] addr);
		iscr_dec_t d;
		logic [31:0] ofs;
		d = '0;
		ofs = '0;
		for (int i = 0; i < NUM_INST; i++) begin
			ofs = addr - INST_BASE[i];
			if (ofs == OFS_CTL || ofs == OFS_STS || ofs == OFS_MSK) begin
				d.hit = 1'b1;
				d.inst = 1'(i);
				d.sel = (ofs == OFS_CTL) ? SEL_CTL : ((ofs == OFS_STS) ? SEL_STS : SEL_MSK);
			end
		end
		return d;
	endfunction

endpackage

/* File: logic/iscr_cell.sv */
// Purpose: one instance of slave control, event status, mask, interrupt and ack answer
// Assumes: events and ack slots come from the slave engine on the same clock
// Notes: all outputs are flip-flops
`timescale 1ns/1ps
module iscr_cell
	import iscr_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register write port
	input wire logic i_we,
	input wire iscr_sel_t i_sel,
	input wire logic [15:0] i_wdata,
	input wire logic [1:0] i_wbe,
	// slave engine side
	input wire iscr_evt_t i_evt,
	input wire iscr_ack_t i_ack,
	// state out
	output logic [15:0] o_ctl,
	output logic [15:0] o_sts,
	output logic [15:0] o_msk,
	output logic o_irq,
	output logic o_nack,
	output logic o_ack_vld
);

	logic [15:0] ctl_r, ctl_nxt, sts_r, sts_nxt, msk_r, msk_nxt, be_m, ev_set;

	// next values; software write of the nack bit beats the hardware clear
	always_comb begin
		be_m = {{8{i_wbe[1]}}, {8{i_wbe[0]}}};
		ctl_nxt = ctl_r;
		// nack bit is spent by the slot it answers
		if (i_ack.req) begin
			ctl_nxt[BIT_NACK] = 1'b0;
		end
		if (i_we && i_sel == SEL_CTL) begin
			ctl_nxt = ((ctl_nxt & ~be_m) | (i_wdata & be_m)) & CTL_WMASK;
		end
		// events only latch while their enable is set
		ev_set = 16'h0000;
		ev_set[BIT_TX] = i_evt.tx_done & ctl_r[BIT_TX];
		ev_set[BIT_RX] = i_evt.rx_done & ctl_r[BIT_RX];
		ev_set[BIT_STOP] = i_evt.stop_det & ctl_r[BIT_STOP];
		// write one to clear, a same-cycle event wins
		sts_nxt = sts_r;
		if (i_we && i_sel == SEL_STS) begin
			sts_nxt = sts_r & ~(i_wdata & be_m & EVT_MASK);
		end
		sts_nxt = sts_nxt | ev_set;
		msk_nxt = msk_r;
		if (i_we && i_sel == SEL_MSK) begin
			msk_nxt = ((msk_r & ~be_m) | (i_wdata & be_m)) & EVT_MASK;
		end
	end

	// register state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctl_r <= CTL_RST;
			sts_r <= STS_RST;
			msk_r <= MSK_RST;
		end else begin
			ctl_r <= ctl_nxt;
			sts_r <= sts_nxt;
			msk_r <= msk_nxt;
		end
	end

	// merged level interrupt, in step with status
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(sts_nxt & msk_nxt);
		end
	end

	// hardware decision unless the forced nack is armed
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_nack <= 1'b0;
			o_ack_vld <= 1'b0;
		end else begin
			o_ack_vld <= i_ack.req;
			if (i_ack.req) begin
				o_nack <= ctl_r[BIT_NACK] | ~i_ack.hw_ack;
			end
		end
	end

	assign o_ctl = ctl_r;
	assign o_sts = sts_r;
	assign o_msk = msk_r;

endmodule // iscr_cell

/* File: tb/iscr_eng_model.sv */
// Purpose: slave engine stand-in driving event pulses and ack slots
// Assumes: same clock as the register block
// Notes: hw_ack is turned over outside slots so a stale value never looks valid
`timescale 1ns/1ps
module iscr_eng_model
	import iscr_pkg::*;
(
	// clock
	input wire logic i_clk,
	// engine outputs
	output iscr_evt_t [NUM_INST-1:0] o_evt,
	output iscr_ack_t [NUM_INST-1:0] o_ack
);
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial begin
		o_evt = '0;
		o_ack = '0;
	end

	// one-cycle event pulse, k 2 tx, 1 rx, 0 stop
	task automatic fire(input int g, input int k);
		@(posedge i_clk);
		o_evt[g] <= iscr_evt_t'(3'(1 << k));
		@(posedge i_clk);
		o_evt[g] <= '0;
	endtask

	task automatic slot(input int g, input logic hw);
		@(posedge i_clk);
		o_ack[g] <= '{req: 1'b1, hw_ack: hw};
		@(posedge i_clk);
		o_ack[g] <= '{req: 1'b0, hw_ack: ~hw};
	endtask
endmodule // iscr_eng_model

/* File: tb/iscr_top_test.sv */
// Purpose: self-checking bench for the i2c slave control register block
// Assumes: axi4-lite master tasks, bounded waits
// Notes: irq and ack outputs are judged at the falling edge after the causing edge, bus responses at the rising edge that shows valid
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module iscr_top_test;
	import iscr_pkg::*;
	logic clk = 0, rst = 1;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [3:0] wstrb = 0, be = 4'h3;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [NUM_INST-1:0] irq, nack, ackv;
	iscr_evt_t [NUM_INST-1:0] evt;
	iscr_ack_t [NUM_INST-1:0] ack;
	int error_cnt = 0, checked = 0;

	iscr_top i_iscr_top (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_EVT(evt),
		.I_ACK_REQ(ack), .O_IRQ(irq), .O_NACK(nack), .O_ACK_VALID(ackv));
	iscr_eng_model i_iscr_eng_model (.i_clk(clk), .o_evt(evt), .o_ack(ack));

	// ----------------------------------------
	// clock and closing
	// ----------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic finish_test;
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// both channels offered at once, held until each is taken
	task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= be;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) begin error_cnt++; finish_test(); end
		`CHK(bresp, er)
	endtask

	task automatic rd(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 50) begin error_cnt++; finish_test(); end
		`CHK(rdata, {16'h0000, d})
		`CHK(rresp, er)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values, reserved bits, unmapped places, byte lanes
	task automatic t_regs;
		for (int g = 0; g < NUM_INST; g++) begin
			rd(INST_BASE[g], 16'h0000, RESP_OKAY);
			rd(INST_BASE[g] + OFS_STS, 16'h0000, RESP_OKAY);
			rd(INST_BASE[g] + OFS_MSK, 16'h0700, RESP_OKAY);
			wr(INST_BASE[g], 16'hffff, RESP_OKAY);
			rd(INST_BASE[g], 16'h07ff, RESP_OKAY);
			wr(INST_BASE[g], 16'h0000, RESP_OKAY);
		end
		rd(32'hffff08a4, 16'h0000, RESP_SLVERR);
		wr(32'hffff08ac, 16'hffff, RESP_SLVERR);
		rd(ADDR_CTL0, 16'h0000, RESP_OKAY);
		// only the strobed byte lane takes the write
		be = 4'h1;
		wr(ADDR_CTL0, 16'hffff, RESP_OKAY);
		rd(ADDR_CTL0, 16'h00ff, RESP_OKAY);
		be = 4'h2;
		wr(ADDR_CTL0, 16'h0500, RESP_OKAY);
		rd(ADDR_CTL0, 16'h05ff, RESP_OKAY);
		be = 4'h3;
		wr(ADDR_CTL0, 16'h0000, RESP_OKAY);
	endtask

	// each event enabled, then disabled, per instance
	task automatic t_events;
		logic [15:0] b;
		for (int g = 0; g < NUM_INST; g++) begin
			for (int k = 0; k < 3; k++) begin
				b = 16'h0100 << k;
				wr(INST_BASE[g], b, RESP_OKAY);
				i_iscr_eng_model.fire(g, k);
				@(negedge clk);
				`CHK(irq[g], 1'b1)
				`CHK(irq[1-g], 1'b0)
				rd(INST_BASE[g] + OFS_STS, b, RESP_OKAY);
				wr(INST_BASE[g] + OFS_STS, b, RESP_OKAY);
				@(negedge clk);
				`CHK(irq[g], 1'b0)
				wr(INST_BASE[g], 16'h0700 & ~b, RESP_OKAY);
				i_iscr_eng_model.fire(g, k);
				@(negedge clk);
				`CHK(irq[g], 1'b0)
				rd(INST_BASE[g] + OFS_STS, 16'h0000, RESP_OKAY);
			end
			// masked event is remembered but held off the line
			wr(INST_BASE[g] + OFS_MSK, 16'h0000, RESP_OKAY);
			i_iscr_eng_model.fire(g, 0);
			@(negedge clk);
			`CHK(irq[g], 1'b0)
			wr(INST_BASE[g] + OFS_MSK, 16'h0700, RESP_OKAY);
			@(negedge clk);
			`CHK(irq[g], 1'b1)
			wr(INST_BASE[g] + OFS_STS, 16'h0100, RESP_OKAY);
			@(negedge clk);
			`CHK(irq[g], 1'b0)
			wr(INST_BASE[g], 16'h0000, RESP_OKAY);
		end
	endtask

	// engine choice, then forced one-shot not-acknowledge
	task automatic t_nack;
		for (int g = 0; g < NUM_INST; g++) begin
			i_iscr_eng_model.slot(g, 1'b1);
			@(negedge clk);
			`CHK({ackv[g], nack[g]}, 2'b10)
			i_iscr_eng_model.slot(g, 1'b0);
			@(negedge clk);
			`CHK({ackv[g], nack[g]}, 2'b11)
			wr(INST_BASE[g], 16'h0080, RESP_OKAY);
			rd(INST_BASE[g], 16'h0080, RESP_OKAY);
			i_iscr_eng_model.slot(g, 1'b1);
			@(negedge clk);
			`CHK({ackv[g], nack[g], ackv[1-g]}, 3'b110)
			rd(INST_BASE[g], 16'h0000, RESP_OKAY);
			i_iscr_eng_model.slot(g, 1'b1);
			@(negedge clk);
			`CHK({ackv[g], nack[g]}, 2'b10)
			@(negedge clk);
			`CHK(ackv[g], 1'b0)
		end
	endtask

	// mid-run reset brings words, flags and answers back to reset values
	task automatic t_reset;
		wr(ADDR_CTL1, 16'h0780, RESP_OKAY);
		wr(ADDR_CTL1 + OFS_MSK, 16'h0000, RESP_OKAY);
		i_iscr_eng_model.fire(1, 1);
		i_iscr_eng_model.slot(1, 1'b1);
		@(negedge clk);
		`CHK(nack[1], 1'b1)
		rd(ADDR_CTL1 + OFS_STS, 16'h0200, RESP_OKAY);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK({irq, nack, ackv}, 6'h00)
		rd(ADDR_CTL1, 16'h0000, RESP_OKAY);
		rd(ADDR_CTL1 + OFS_STS, 16'h0000, RESP_OKAY);
		rd(ADDR_CTL1 + OFS_MSK, 16'h0700, RESP_OKAY);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK({irq, nack, ackv}, 6'h00)
		t_regs();
		t_events();
		t_nack();
		t_reset();
		finish_test();
	end
endmodule // iscr_top_test
